// ===== common/tof_pkg.sv
// Constants shared by the timer output flip-flop and interrupt flag block.
package tof_pkg;

    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int         ADDR_W     = 8;
    localparam int         DATA_W     = 32;
    localparam logic [7:0] OFS_FFCTL  = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK   = 8'h08;

    // ------------------------------------------------------------
    // Output flip-flop control fields
    // ------------------------------------------------------------
    localparam int         FORCE_LSB    = 0;
    localparam int         TGL_LSB      = 2;
    localparam int         TGL_W        = 4;
    localparam int         TGL_CMP0     = 0;
    localparam int         TGL_CMP1     = 1;
    localparam int         TGL_CAP0     = 2;
    localparam int         TGL_CAP1     = 3;
    localparam int         FIXED_LSB    = 6;
    localparam logic [1:0] FIXED_ONES   = 2'h3;
    localparam logic [1:0] FORCE_INVERT = 2'h0;
    localparam logic [1:0] FORCE_SET    = 2'h1;
    localparam logic [1:0] FORCE_CLEAR  = 2'h2;
    localparam logic [1:0] FORCE_KEEP   = 2'h3;

    // ------------------------------------------------------------
    // Status and mask fields
    // ------------------------------------------------------------
    localparam int         FLAG_W   = 3;
    localparam int         FLAG_CMP0 = 0;
    localparam int         FLAG_CMP1 = 1;
    localparam int         FLAG_OVF  = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] TGL_RST  = 4'h0;
    localparam logic [2:0] FLAG_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic       TFF_RST  = 1'b0;

endpackage : tof_pkg

// ===== src/tof_timer_ff.sv
// Timer output flip-flop, event flags and interrupt masking with an APB slave.
//
// Behaviour
// - Capture-1 enable bit 5 toggles output flip-flop.
// - Capture-0 enable bit 4 toggles output flip-flop.
// - Compare-1 enable bit 3 toggles on match.
// - Compare-0 enable bit 2 toggles on match.
// - Force field write 00 inverts flip-flop.
// - Force 01 sets, 10 clears flip-flop.
// - Force 11 keeps; field reads 11.
// - Overflow sets status bit 2.
// - Compare-1 match sets status bit 1.
// - Compare-0 match sets status bit 0.
// - Flags set regardless of interrupt mask.
// - Interrupt only for unmasked set flags.
// - Status read clears its flags.
// - Mask bits 2..0, reset zero, upper zero.
// - Compare-1 match clears counter when enabled.
module tof_timer_ff
    import tof_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              match0_pulse,
    input  wire logic              match1_pulse,
    input  wire logic              capture0_pulse,
    input  wire logic              capture1_pulse,
    input  wire logic              overflow_pulse,
    input  wire logic              clear_on_compare1_enable,
    output logic                   counter_clear,
    output logic                   timer_output_flipflop,
    output logic                   irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [TGL_W-1:0]  tgl_en_q;
    logic [FLAG_W-1:0] flag_q;
    logic [FLAG_W-1:0] flag_d;
    logic [FLAG_W-1:0] mask_q;
    logic              tff_q;
    logic              tff_d;
    logic [DATA_W-1:0] prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    logic              irq_q;
    logic              clr_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire setup_ph   = psel & ~penable;
    wire access_ok  = psel & penable & pready_q;
    wire wr_done    = access_ok & pwrite;
    wire rd_done    = access_ok & ~pwrite;
    wire sel_ffctl  = (paddr == OFS_FFCTL);
    wire sel_status = (paddr == OFS_STATUS);
    wire sel_mask   = (paddr == OFS_MASK);
    wire addr_ok    = sel_ffctl | sel_status | sel_mask;
    wire force_wr   = wr_done & sel_ffctl;
    wire mask_wr    = wr_done & sel_mask;
    wire status_rd  = rd_done & sel_status;

    wire [1:0] force_code = pwdata[FORCE_LSB +: 2];

    // ------------------------------------------------------------
    // Events and toggle triggers
    // ------------------------------------------------------------
    wire [FLAG_W-1:0] events = {overflow_pulse, match1_pulse, match0_pulse};
    wire [TGL_W-1:0]  tgl_src = {capture1_pulse, capture0_pulse,
                                 match1_pulse, match0_pulse};
    // Any number of coinciding enabled triggers gives one inversion.
    wire hw_toggle = |(tgl_en_q & tgl_src);

    // Only the flags that were returned by the read are cleared, so an
    // event landing between setup and access is never lost.
    wire [FLAG_W-1:0] flag_clr = status_rd ? prdata_q[FLAG_W-1:0] : FLAG_RST;

    wire [DATA_W-1:0] ffctl_word = {24'h0, FIXED_ONES, tgl_en_q, FORCE_KEEP};
    wire [DATA_W-1:0] status_word = {29'h0, flag_q};
    wire [DATA_W-1:0] mask_word = {29'h0, mask_q};
    wire [DATA_W-1:0] rd_word = sel_ffctl  ? ffctl_word  :
                                sel_status ? status_word :
                                sel_mask   ? mask_word   : 32'h0;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        flag_d = (flag_q & ~flag_clr) | events;
    end

    always_comb begin
        tff_d = hw_toggle ? ~tff_q : tff_q;
        if (force_wr) begin
            case (force_code)
                FORCE_INVERT: tff_d = ~tff_q;
                FORCE_SET:    tff_d = 1'b1;
                FORCE_CLEAR:  tff_d = 1'b0;
                default:      tff_d = hw_toggle ? ~tff_q : tff_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= setup_ph;
            pslverr_q <= setup_ph & ~addr_ok;
            prdata_q  <= (setup_ph & ~pwrite) ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgl_en_q <= TGL_RST;
            mask_q   <= MASK_RST;
        end else begin
            if (force_wr) begin
                tgl_en_q <= pwdata[TGL_LSB +: TGL_W];
            end
            if (mask_wr) begin
                mask_q <= pwdata[FLAG_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= FLAG_RST;
            tff_q  <= TFF_RST;
            irq_q  <= 1'b0;
            clr_q  <= 1'b0;
        end else begin
            flag_q <= flag_d;
            tff_q  <= tff_d;
            irq_q  <= |(flag_q & mask_q);
            clr_q  <= match1_pulse & clear_on_compare1_enable;
        end
    end

    assign prdata                = prdata_q;
    assign pready                = pready_q;
    assign pslverr               = pslverr_q;
    assign counter_clear         = clr_q;
    assign timer_output_flipflop = tff_q;
    assign irq                   = irq_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_rd_setup(logic sel);
        psel && !penable && !pwrite && sel;
    endsequence

    sequence s_rd_access;
        psel && penable && pready;
    endsequence

    a_cap1_toggle: assert property (
        !force_wr && capture1_pulse && tgl_en_q[TGL_CAP1] |=> tff_q != $past(tff_q))
        else $error("capture-1 trigger did not toggle");

    a_cap0_toggle: assert property (
        !force_wr && capture0_pulse && tgl_en_q[TGL_CAP0] |=> tff_q != $past(tff_q))
        else $error("capture-0 trigger did not toggle");

    a_cmp_toggle: assert property (
        !force_wr && match1_pulse && tgl_en_q[TGL_CMP1] |=> tff_q != $past(tff_q))
        else $error("compare-1 trigger did not toggle");

    a_cmp0_toggle: assert property (
        !force_wr && match0_pulse && tgl_en_q[TGL_CMP0] |=> tff_q != $past(tff_q))
        else $error("compare-0 trigger did not toggle");

    a_idle_ff_stable: assert property (
        !force_wr && !(|(tgl_en_q & tgl_src)) |=> $stable(tff_q))
        else $error("output flip-flop moved without cause");

    a_force_invert: assert property (
        force_wr && force_code == FORCE_INVERT |=> tff_q != $past(tff_q))
        else $error("software invert failed");

    a_force_set_clr: assert property (
        force_wr && force_code[1] != force_code[0] |=> tff_q == $past(force_code[0]))
        else $error("software set or clear failed");

    a_force_field_reads: assert property (
        s_rd_setup(sel_ffctl) |=> prdata[1:0] == FORCE_KEEP && prdata[7:6] == FIXED_ONES)
        else $error("force field did not read as ones");

    a_flags_set: assert property (
        events != FLAG_RST |=> (flag_q & $past(events)) == $past(events))
        else $error("event flag not recorded");

    a_read_clears: assert property (
        s_rd_setup(sel_status) ##1 s_rd_access ##0 (events == FLAG_RST)
        |=> (flag_q & $past(prdata_q[FLAG_W-1:0])) == FLAG_RST)
        else $error("status read did not clear flags");

    a_irq_follows: assert property (
        (|(flag_q & mask_q)) |=> irq ##0 ((!$past(flag_q[FLAG_OVF]) || $past(mask_q[FLAG_OVF])) || irq))
        else $error("interrupt missing for unmasked flag");

    a_irq_masked: assert property (
        !(|(flag_q & mask_q)) |=> !irq)
        else $error("interrupt raised with nothing unmasked");

    a_mask_upper_zero: assert property (
        s_rd_setup(sel_mask) |=> prdata[DATA_W-1:FLAG_W] == 29'h0 && prdata[FLAG_W-1:0] == $past(mask_q))
        else $error("mask register read wrong");

    a_counter_clear: assert property (
        match1_pulse && clear_on_compare1_enable |=> counter_clear && flag_q[FLAG_CMP1])
        else $error("compare-1 match did not clear counter");

    // ------------------------------------------------------------
    // Output flip-flop checks
    // ------------------------------------------------------------
    // A keep code leaves the hardware triggers in charge of the flip-flop.
    a_keep_hw_toggle: assert property (
        force_wr && force_code == FORCE_KEEP && hw_toggle |=> tff_q != $past(tff_q))
        else $error("hardware trigger lost during keep write");

    a_keep_no_trig: assert property (
        force_wr && force_code == FORCE_KEEP && !hw_toggle |=> $stable(tff_q))
        else $error("keep code moved the flip-flop");

    a_force_set: assert property (
        force_wr && force_code == FORCE_SET |=> tff_q)
        else $error("software set failed");

    a_force_clear: assert property (
        force_wr && force_code == FORCE_CLEAR |=> !tff_q)
        else $error("software clear failed");

    a_multi_toggle: assert property (
        !force_wr && $countones(tgl_en_q & tgl_src) > 1 |=> tff_q != $past(tff_q))
        else $error("coinciding triggers did not invert once");

    a_cap1_ignored: assert property (
        !force_wr && capture1_pulse && (tgl_en_q & tgl_src) == 4'h0 |=> $stable(tff_q))
        else $error("disabled capture-1 trigger toggled");

    a_cap0_ignored: assert property (
        !force_wr && capture0_pulse && (tgl_en_q & tgl_src) == 4'h0 |=> $stable(tff_q))
        else $error("disabled capture-0 trigger toggled");

    a_cmp1_ignored: assert property (
        !force_wr && match1_pulse && (tgl_en_q & tgl_src) == 4'h0 |=> $stable(tff_q))
        else $error("disabled compare-1 trigger toggled");

    a_cmp0_ignored: assert property (
        !force_wr && match0_pulse && (tgl_en_q & tgl_src) == 4'h0 |=> $stable(tff_q))
        else $error("disabled compare-0 trigger toggled");

    a_ctrl_write: assert property (
        force_wr |=> tgl_en_q == $past(pwdata[TGL_LSB +: TGL_W]))
        else $error("trigger enables not stored");

    a_ctrl_read: assert property (
        s_rd_setup(sel_ffctl) |=> prdata[5:2] == $past(tgl_en_q) && prdata[31:8] == 24'h0)
        else $error("control register read wrong");

    // ------------------------------------------------------------
    // Flag and interrupt checks
    // ------------------------------------------------------------
    // Every flag must follow its own event, whatever the mask holds.
    a_ovf_flag: assert property (
        overflow_pulse |=> flag_q[FLAG_OVF])
        else $error("overflow flag not set");

    a_cmp1_flag: assert property (
        match1_pulse |=> flag_q[FLAG_CMP1])
        else $error("compare-1 flag not set");

    a_cmp0_flag: assert property (
        match0_pulse |=> flag_q[FLAG_CMP0])
        else $error("compare-0 flag not set");

    a_ovf_no_spurious: assert property (
        !flag_q[FLAG_OVF] && !overflow_pulse |=> !flag_q[FLAG_OVF])
        else $error("overflow flag set without event");

    a_flag_when_masked: assert property (
        overflow_pulse && !mask_q[FLAG_OVF] |=> flag_q[FLAG_OVF])
        else $error("masked event not recorded");

    a_flag_hold: assert property (
        !status_rd && events == FLAG_RST |=> $stable(flag_q))
        else $error("flags changed without read or event");

    a_event_wins: assert property (
        status_rd && events != FLAG_RST |=> (flag_q & $past(events)) == $past(events))
        else $error("event lost during status read");

    a_status_read: assert property (
        s_rd_setup(sel_status) |=> prdata[DATA_W-1:FLAG_W] == 29'h0 && prdata[FLAG_W-1:0] == $past(flag_q))
        else $error("status register read wrong");

    a_ovf_irq: assert property (
        flag_q[FLAG_OVF] && mask_q[FLAG_OVF] |=> irq)
        else $error("overflow interrupt missing");

    a_cmp1_irq: assert property (
        flag_q[FLAG_CMP1] && mask_q[FLAG_CMP1] |=> irq)
        else $error("compare-1 interrupt missing");

    a_cmp0_irq: assert property (
        flag_q[FLAG_CMP0] && mask_q[FLAG_CMP0] |=> irq)
        else $error("compare-0 interrupt missing");

    a_mask_write: assert property (
        mask_wr |=> mask_q == $past(pwdata[FLAG_W-1:0]))
        else $error("mask bits not stored");

    a_mask_hold: assert property (
        !mask_wr |=> $stable(mask_q))
        else $error("mask bits changed without write");

    a_no_clear: assert property (
        !(match1_pulse && clear_on_compare1_enable) |=> !counter_clear)
        else $error("counter clear without enabled match");

    // ------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------
    // The slave answers in the cycle after setup and never stretches it.
    a_pready_after_setup: assert property (
        setup_ph |=> pready)
        else $error("ready missing after setup");

    a_pready_single: assert property (
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    a_slverr_unmapped: assert property (
        setup_ph && !addr_ok |=> pslverr && pready)
        else $error("unmapped address not flagged");

    a_idle_prdata: assert property (
        !pready |-> prdata == 32'h0)
        else $error("read data outside access cycle");

    a_write_no_rdata: assert property (
        wr_done |-> prdata == 32'h0)
        else $error("read data during write access");

endmodule : tof_timer_ff

// ===== tb/tof_timer_ff_tb_top.sv
// Self-checking testbench for the timer output flip-flop and event flag block.
module tof_timer_ff_tb_top
    import tof_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              pclk    = 1'b0;
    logic              presetn = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [ADDR_W-1:0] paddr   = '0;
    logic [DATA_W-1:0] pwdata  = '0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic [4:0]        ev      = '0;
    logic              cce     = 1'b0;
    logic              counter_clear;
    logic              tff;
    logic              irq;
    logic [DATA_W-1:0] rd;
    logic              er;
    int                error_cnt   = 0;
    int                checks_done = 0;

    always #20 pclk = ~pclk;

    tof_timer_ff tof_timer_ff_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .match0_pulse(ev[0]), .match1_pulse(ev[1]), .overflow_pulse(ev[2]),
        .capture0_pulse(ev[3]), .capture1_pulse(ev[4]), .clear_on_compare1_enable(cce),
        .counter_clear(counter_clear), .timer_output_flipflop(tff), .irq(irq)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; e holds event pulses raised during the access cycle.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [4:0] e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        ev      <= e;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        ev      <= '0;
        @(posedge pclk);
    endtask : apb

    task automatic pulse(input logic [4:0] e);
        ev <= e;
        @(posedge pclk);
        ev <= '0;
        @(posedge pclk);
    endtask : pulse

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        apb(1'b0, OFS_FFCTL, '0, '0); chk(rd, 32'h000000C3);
        apb(1'b0, OFS_MASK, '0, '0); chk(rd, 32'h0);
        apb(1'b0, OFS_STATUS, '0, '0); chk(rd, 32'h0);
        apb(1'b1, OFS_MASK, 32'hFFFFFFFF, '0);
        apb(1'b0, OFS_MASK, '0, '0); chk(rd, 32'h7);
        apb(1'b1, OFS_MASK, 32'h0, '0);
        apb(1'b0, 8'h0C, '0, '0); chk({31'h0, er}, 32'h1);
    endtask : t_reset

    task automatic t_force;
        apb(1'b1, OFS_FFCTL, 32'h1, '0); chk({31'h0, tff}, 32'h1);
        apb(1'b1, OFS_FFCTL, 32'h3, '0); chk({31'h0, tff}, 32'h1);
        apb(1'b1, OFS_FFCTL, 32'h0, '0); chk({31'h0, tff}, 32'h0);
        apb(1'b1, OFS_FFCTL, 32'h0, '0); chk({31'h0, tff}, 32'h1);
        apb(1'b1, OFS_FFCTL, 32'h2, '0); chk({31'h0, tff}, 32'h0);
        apb(1'b0, OFS_FFCTL, '0, '0); chk(rd, 32'h000000C3);
    endtask : t_force

    task automatic t_toggle;
        logic [4:0] evb [4] = '{5'h01, 5'h02, 5'h08, 5'h10};
        logic       e;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_FFCTL, 32'h3, '0);
            e = tff;
            pulse(evb[i]); chk({31'h0, tff}, {31'h0, e});
            apb(1'b1, OFS_FFCTL, 32'h3 | (32'h1 << (i + 2)), '0);
            pulse(evb[i]); chk({31'h0, tff}, {31'h0, ~e});
        end
        apb(1'b1, OFS_FFCTL, 32'h3F, '0);
        e = tff;
        pulse(5'h1B); chk({31'h0, tff}, {31'h0, ~e});
        apb(1'b1, OFS_FFCTL, 32'h3D, 5'h1B); chk({31'h0, tff}, 32'h1);
        apb(1'b1, OFS_FFCTL, 32'h3E, 5'h1B); chk({31'h0, tff}, 32'h0);
        apb(1'b1, OFS_FFCTL, 32'h3F, 5'h1B); chk({31'h0, tff}, 32'h1);
    endtask : t_toggle

    task automatic t_flags;
        cce <= 1'b1;
        apb(1'b0, OFS_STATUS, '0, '0);
        pulse(5'h07); chk({31'h0, counter_clear}, 32'h1);
        apb(1'b0, OFS_STATUS, '0, '0); chk(rd, 32'h7);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, OFS_STATUS, '0, '0); chk(rd, 32'h0);
        cce <= 1'b0;
        pulse(5'h02); chk({31'h0, counter_clear}, 32'h0);
        apb(1'b0, OFS_STATUS, '0, 5'h04); chk(rd, 32'h2);
        apb(1'b0, OFS_STATUS, '0, '0); chk(rd, 32'h4);
    endtask : t_flags

    task automatic t_irq;
        apb(1'b1, OFS_MASK, 32'h4, '0);
        pulse(5'h01);
        @(posedge pclk); chk({31'h0, irq}, 32'h0);
        pulse(5'h04);
        @(posedge pclk); chk({31'h0, irq}, 32'h1);
        apb(1'b0, OFS_STATUS, '0, '0); chk(rd, 32'h5);
        @(posedge pclk); chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFS_MASK, 32'h0, '0);
    endtask : t_irq

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_force();
        t_toggle();
        t_flags();
        t_irq();
        end_sim();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        end_sim();
    end

endmodule : tof_timer_ff_tb_top
